// *** vds_pkg.sv ***
package vds_pkg;

   // Register indices on the programmed-access port
   localparam logic [2:0] VDS_IDX_MEMORY_ADDRESS       = 3'h0;
   localparam logic [2:0] VDS_IDX_MEMORY_ADDRESS_DEF   = 3'h1;
   localparam logic [2:0] VDS_IDX_LINE_SIZE_COUNTS     = 3'h2;
   localparam logic [2:0] VDS_IDX_LINE_STRIDE_ZOOM     = 3'h3;
   localparam logic [2:0] VDS_IDX_DEVICE_TARGET        = 3'h4;
   localparam logic [2:0] VDS_IDX_DEVICE_TARGET_GO     = 3'h5;
   localparam logic [2:0] VDS_IDX_TRANSFER_MODE        = 3'h6;
   localparam logic [2:0] VDS_IDX_LINE_PROGRESS        = 3'h7;

   // Field positions
   localparam int VDS_MODE_LONG_BIT  = 6;
   localparam int VDS_MODE_SNOOP_BIT = 5;
   localparam int VDS_MODE_DIR_BIT   = 4;
   localparam int VDS_MODE_FILL_BIT  = 3;
   localparam int VDS_MODE_SYNC_BIT  = 2;
   localparam int VDS_HALF_LSB       = 16;
   localparam int VDS_MEM_TOP_BIT    = 31;

   // Transfer-type codes
   localparam logic [1:0] VDS_TYPE_MEM_READ  = 2'h0;
   localparam logic [1:0] VDS_TYPE_MEM_WRITE = 2'h2;

   // Default descriptor
   localparam logic [15:0] VDS_DEF_LINE_COUNT = 16'h0001;
   localparam logic [15:0] VDS_DEF_STRIDE     = 16'h0000;
   localparam logic [9:0]  VDS_DEF_ZOOM       = 10'h001;
   localparam logic [15:0] VDS_DEF_WIDTH      = 16'h000C;
   localparam logic [6:0]  VDS_DEF_MODE       = 7'h28;

   // Values after reset, and the beat buffer depth
   localparam logic [31:0] VDS_RST_WORD  = 32'h0000_0000;
   localparam logic [6:0]  VDS_RST_MODE  = 7'h00;
   localparam logic [1:0]  VDS_BUF_DEPTH = 2'h2;

   typedef enum logic [3:0] {
      VDS_IDLE = 4'b0001,
      VDS_SYNC = 4'b0010,
      VDS_RUN  = 4'b0100,
      VDS_STOP = 4'b1000
   } vds_state_t;

   // One beat handed to the bus side
   typedef struct packed {
      logic [31:0] memAddr;
      logic [31:0] busAddr;
      logic [31:0] fillData;
      logic        memWrite;
      logic        fillNoBus;
      logic        snoop;
      logic        longBurst;
   } vds_beat_t;

endpackage

// *** vds_sequencer.sv ***
module vds_sequencer
   import vds_pkg::*;
#(
   parameter int BUF_DEPTH = 2
) (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [2:0]  regIndex,
   input  wire logic [31:0] regWrData,
   output logic      [31:0] regRdData,
   output logic             regRdValid,
   input  wire logic        translateEn,
   input  wire logic [31:0] protectMask,
   input  wire logic [31:0] addressSubstitute,
   input  wire logic        externalSyncIn,
   input  wire logic        haltReq,
   input  wire logic        faultIn,
   output vds_beat_t        beatData,
   output logic             beatValid,
   input  wire logic        beatReady,
   output logic             busy,
   output logic             completePulse,
   output logic             faultPulse,
   output logic             typeUnsupported
);

   if (BUF_DEPTH != 2) begin : gBadDepth
      $error("vds_sequencer: BUF_DEPTH must be 2");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Descriptor state

   vds_state_t  state;
   logic [31:0] memoryAddress;
   logic [15:0] lineCount;
   logic [15:0] lineWidth;
   logic [9:0]  lineZoom;
   logic [15:0] stride;
   logic [31:0] targetAddress;
   logic [6:0]  transferMode;
   logic [9:0]  zoomCount;
   logic [15:0] byteCount;

   logic        idleLike;
   logic        bufInReady;
   logic        emitBeat;
   logic        passEnd;
   logic [9:0]  zoomLeft;
   logic        dirUp;
   logic        wrMem;
   logic        wrDef;
   logic        wrSize;
   logic        wrStride;
   logic        wrTarget;
   logic        wrGo;
   logic        wrMode;
   logic        wrCount;
   vds_beat_t   newBeat;

   // Register writes are taken only in the idle and stopped states, not while waiting for sync or running
   function automatic logic vds_wr_hit(input logic       wr,
                                       input logic       idle,
                                       input logic [2:0] idx,
                                       input logic [2:0] want);
      vds_wr_hit = wr && idle && (idx == want);
   endfunction

   assign idleLike = (state == VDS_IDLE) || (state == VDS_STOP);
   assign wrMem    = vds_wr_hit(regWrite, idleLike, regIndex,
                                VDS_IDX_MEMORY_ADDRESS);
   assign wrDef    = vds_wr_hit(regWrite, idleLike, regIndex,
                                VDS_IDX_MEMORY_ADDRESS_DEF);
   assign wrSize   = vds_wr_hit(regWrite, idleLike, regIndex,
                                VDS_IDX_LINE_SIZE_COUNTS);
   assign wrStride = vds_wr_hit(regWrite, idleLike, regIndex,
                                VDS_IDX_LINE_STRIDE_ZOOM);
   assign wrTarget = vds_wr_hit(regWrite, idleLike, regIndex,
                                VDS_IDX_DEVICE_TARGET);
   assign wrGo     = vds_wr_hit(regWrite, idleLike, regIndex,
                                VDS_IDX_DEVICE_TARGET_GO);
   assign wrMode   = vds_wr_hit(regWrite, idleLike, regIndex,
                                VDS_IDX_TRANSFER_MODE);
   assign wrCount  = vds_wr_hit(regWrite, idleLike, regIndex,
                                VDS_IDX_LINE_PROGRESS);

   assign dirUp    = transferMode[VDS_MODE_DIR_BIT];
   // Pass end rewinds for another zoom pass or steps to the next line
   assign passEnd  = (state == VDS_RUN) && lineCount != 16'h0000
                     && byteCount == 16'h0000 && !haltReq && !faultIn;
   assign emitBeat = (state == VDS_RUN) && lineCount != 16'h0000
                     && byteCount != 16'h0000 && bufInReady
                     && !haltReq && !faultIn;
   assign zoomLeft = (zoomCount == 10'h000) ? 10'h000 : zoomCount - 10'h001;

   // Translated addresses drop the top bit
   function automatic logic [31:0] vds_mem_phys(input logic [31:0] a,
                                                input logic xl);
      vds_mem_phys = a;
      if (xl) begin
         vds_mem_phys[VDS_MEM_TOP_BIT] = 1'b0;
      end
   endfunction

   always_comb begin
      newBeat.memAddr   = vds_mem_phys(memoryAddress, translateEn);
      newBeat.busAddr   = (targetAddress & ~protectMask)
                          | (addressSubstitute & protectMask);
      newBeat.fillData  = targetAddress;
      newBeat.memWrite  = transferMode[1:0] == VDS_TYPE_MEM_WRITE;
      newBeat.fillNoBus = newBeat.memWrite
                          && transferMode[VDS_MODE_FILL_BIT];
      newBeat.snoop     = transferMode[VDS_MODE_SNOOP_BIT];
      newBeat.longBurst = transferMode[VDS_MODE_LONG_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control state machine

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state           <= VDS_IDLE;
         completePulse   <= 1'b0;
         faultPulse      <= 1'b0;
         typeUnsupported <= 1'b0;
      end else begin
         completePulse <= 1'b0;
         faultPulse    <= 1'b0;
         case (state)
            VDS_IDLE, VDS_STOP: begin
               // An accumulation type ends at once and moves no beats
               if (wrGo) begin
                  if (transferMode[0]) begin
                     typeUnsupported <= 1'b1;
                     completePulse   <= 1'b1;
                     state           <= VDS_IDLE;
                  end else begin
                     typeUnsupported <= 1'b0;
                     if (transferMode[VDS_MODE_SYNC_BIT]) begin
                        state <= VDS_SYNC;
                     end else begin
                        state <= VDS_RUN;
                     end
                  end
               end
            end
            VDS_SYNC: begin
               if (haltReq) begin
                  state <= VDS_STOP;
               end else if (externalSyncIn) begin
                  state <= VDS_RUN;
               end
            end
            VDS_RUN: begin
               if (faultIn) begin
                  state      <= VDS_STOP;
                  faultPulse <= 1'b1;
               end else if (haltReq) begin
                  state <= VDS_STOP;
               end else if (lineCount == 16'h0000) begin
                  state         <= VDS_IDLE;
                  completePulse <= 1'b1;
               end
            end
            default: begin
               state <= VDS_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Descriptor registers and address sequencing

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         memoryAddress <= VDS_RST_WORD;
         lineCount     <= VDS_RST_WORD[15:0];
         lineWidth     <= VDS_RST_WORD[15:0];
         lineZoom      <= VDS_RST_WORD[9:0];
         stride        <= VDS_RST_WORD[15:0];
         zoomCount     <= VDS_RST_WORD[9:0];
         byteCount     <= VDS_RST_WORD[15:0];
      end else if (emitBeat) begin
         byteCount <= byteCount - 16'h0001;
         if (dirUp) begin
            memoryAddress <= memoryAddress + 32'h0000_0001;
         end else begin
            memoryAddress <= memoryAddress - 32'h0000_0001;
         end
      end else if (passEnd) begin
         byteCount <= lineWidth;
         if (zoomLeft != 10'h000) begin
            zoomCount <= zoomLeft;
            if (dirUp) begin
               memoryAddress <= memoryAddress - {16'h0000, lineWidth};
            end else begin
               memoryAddress <= memoryAddress + {16'h0000, lineWidth};
            end
         end else begin
            zoomCount     <= lineZoom;
            lineCount     <= lineCount - 16'h0001;
            memoryAddress <= memoryAddress
                             + {{16{stride[15]}}, stride};
         end
      end else if (wrDef) begin
         memoryAddress <= regWrData;
         lineCount     <= VDS_DEF_LINE_COUNT;
         lineWidth     <= VDS_DEF_WIDTH;
         lineZoom      <= VDS_DEF_ZOOM;
         stride        <= VDS_DEF_STRIDE;
         zoomCount     <= VDS_DEF_ZOOM;
         byteCount     <= VDS_DEF_WIDTH;
      end else if (wrMem) begin
         memoryAddress <= regWrData;
      end else if (wrSize) begin
         lineCount <= regWrData[31:VDS_HALF_LSB];
         lineWidth <= regWrData[15:0];
         byteCount <= regWrData[15:0];
      end else if (wrStride) begin
         lineZoom  <= regWrData[25:VDS_HALF_LSB];
         stride    <= regWrData[15:0];
         zoomCount <= regWrData[25:VDS_HALF_LSB];
      end else if (wrCount) begin
         zoomCount <= regWrData[25:VDS_HALF_LSB];
         byteCount <= regWrData[15:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         targetAddress <= VDS_RST_WORD;
         transferMode  <= VDS_RST_MODE;
      end else if (wrTarget || wrGo) begin
         targetAddress <= regWrData;
      end else if (wrDef) begin
         transferMode <= VDS_DEF_MODE;
      end else if (wrMode) begin
         transferMode <= regWrData[6:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read-back

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         regRdData  <= VDS_RST_WORD;
         regRdValid <= 1'b0;
         busy       <= 1'b0;
      end else begin
         regRdValid <= regRead;
         busy       <= (state == VDS_SYNC) || (state == VDS_RUN);
         if (regRead) begin
            case (regIndex)
               VDS_IDX_MEMORY_ADDRESS, VDS_IDX_MEMORY_ADDRESS_DEF: begin
                  regRdData <= memoryAddress;
               end
               VDS_IDX_LINE_SIZE_COUNTS: begin
                  regRdData <= {lineCount, lineWidth};
               end
               VDS_IDX_LINE_STRIDE_ZOOM: begin
                  regRdData <= {6'h00, lineZoom, stride};
               end
               VDS_IDX_DEVICE_TARGET: begin
                  regRdData <= targetAddress;
               end
               VDS_IDX_TRANSFER_MODE: begin
                  regRdData <= {25'h0000000, transferMode};
               end
               VDS_IDX_LINE_PROGRESS: begin
                  regRdData <= {6'h00, zoomCount, byteCount};
               end
               default: begin
                  regRdData <= VDS_RST_WORD;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two-entry beat buffer; output slot is always entry 0

   vds_beat_t  slot [2];
   logic [1:0] fill;
   logic       popBeat;

   assign popBeat    = beatValid && beatReady;
   assign bufInReady = fill != VDS_BUF_DEPTH;
   assign beatData   = slot[0];

   // Entry 0 always feeds the output, so a stalled beat never moves
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         fill      <= 2'h0;
         beatValid <= 1'b0;
         slot[0]   <= '0;
         slot[1]   <= '0;
      end else begin
         if (popBeat && emitBeat) begin
            if (fill == VDS_BUF_DEPTH) begin
               slot[0] <= slot[1];
               slot[1] <= newBeat;
            end else begin
               slot[0] <= newBeat;
            end
         end else if (popBeat) begin
            slot[0]   <= slot[1];
            fill      <= fill - 2'h1;
            beatValid <= fill == VDS_BUF_DEPTH;
         end else if (emitBeat) begin
            slot[fill[0]] <= newBeat;
            fill          <= fill + 2'h1;
            beatValid     <= 1'b1;
         end
      end
   end

endmodule

// *** vds_seq_assertions.sv ***
module vds_seq_checker
   import vds_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [2:0]  regIndex,
   input wire logic [31:0] regRdData,
   input wire logic        regRdValid,
   input wire logic        translateEn,
   input wire logic [31:0] protectMask,
   input wire logic [31:0] addressSubstitute,
   input wire logic        faultIn,
   input wire vds_beat_t   beatData,
   input wire logic        beatValid,
   input wire logic        beatReady,
   input wire logic        busy,
   input wire logic        completePulse,
   input wire logic        faultPulse,
   input wire logic        typeUnsupported
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_read_answer: assert property (regRead |=> regRdValid)
      else $error("read gave no answer");
   a_answer_cause: assert property (regRdValid |-> $past(regRead))
      else $error("answer without read");
   a_go_reads_zero: assert property (
      regRead && regIndex == VDS_IDX_DEVICE_TARGET_GO |=> regRdData == 32'h0)
      else $error("start alias read not zero");
   a_go_starts: assert property (
      regWrite && regIndex == VDS_IDX_DEVICE_TARGET_GO && !busy
      |-> ##[1:4] (busy || completePulse))
      else $error("start write did not start");
   a_beat_hold: assert property (
      beatValid && !beatReady |=> beatValid && $stable(beatData))
      else $error("beat dropped or changed");
   a_fill_read: assert property (
      beatValid && !beatData.memWrite |-> !beatData.fillNoBus)
      else $error("fill on memory read");
   a_bus_protect: assert property (beatValid |->
      ((beatData.busAddr ^ addressSubstitute) & protectMask) == 32'h0)
      else $error("bus address escapes mask");
   a_top_ignored: assert property (
      beatValid && translateEn |-> !beatData.memAddr[31])
      else $error("virtual top bit used");
   a_done_pulse: assert property (completePulse |=> !completePulse)
      else $error("completion longer than one cycle");
   a_fault_cause: assert property (
      faultPulse |-> $past(faultIn) || $past(faultIn, 2))
      else $error("fault pulse without fault");
   a_unsup_done: assert property (
      $rose(typeUnsupported) |-> completePulse && !beatValid)
      else $error("accumulation start not ended at once");
endmodule

bind vds_sequencer vds_seq_checker vds_seq_checker_i (
   .mclk(mclk), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
   .regIndex(regIndex), .regRdData(regRdData), .regRdValid(regRdValid),
   .translateEn(translateEn), .protectMask(protectMask),
   .addressSubstitute(addressSubstitute), .faultIn(faultIn),
   .beatData(beatData), .beatValid(beatValid), .beatReady(beatReady),
   .busy(busy), .completePulse(completePulse), .faultPulse(faultPulse),
   .typeUnsupported(typeUnsupported)
);

// *** vds_beat_sink.sv ***
module vds_beat_sink (
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic stallEn,
   output logic      beatReady
);
   timeunit 1ns;
   timeprecision 100ps;
   // Bus side takes beats, stalling one cycle in three when asked
   always @(negedge mclk or negedge rst_b) begin
      if (!rst_b)
         beatReady <= 1'b0;
      else
         beatReady <= !stallEn || ($urandom % 3 != 0);
   end
endmodule

// *** tb_top.sv ***
module tb_top;
   import vds_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk, rst_b, regWrite, regRead, translateEn, externalSyncIn;
   logic        haltReq, faultIn, stallEn, seen;
   logic [2:0]  regIndex;
   logic [15:0] st;
   logic [31:0] regWrData, protectMask, addressSubstitute, m, finalAddr;
   wire logic [31:0] regRdData;
   wire logic   regRdValid, beatValid, beatReady, busy;
   wire logic   completePulse, faultPulse, typeUnsupported;
   wire vds_beat_t beatData;
   vds_beat_t   expQ[$], gotQ[$];
   int          fail_count, checks, cycles, n;

   vds_sequencer #(.BUF_DEPTH(2)) vds_sequencer_i (
      .mclk(mclk), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
      .regIndex(regIndex), .regWrData(regWrData), .regRdData(regRdData),
      .regRdValid(regRdValid), .translateEn(translateEn),
      .protectMask(protectMask), .addressSubstitute(addressSubstitute),
      .externalSyncIn(externalSyncIn), .haltReq(haltReq), .faultIn(faultIn),
      .beatData(beatData), .beatValid(beatValid), .beatReady(beatReady),
      .busy(busy), .completePulse(completePulse), .faultPulse(faultPulse),
      .typeUnsupported(typeUnsupported));
   vds_beat_sink vds_beat_sink_i (.mclk(mclk), .rst_b(rst_b),
      .stallEn(stallEn), .beatReady(beatReady));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (beatValid === 1'b1 && beatReady === 1'b1)
         gotQ.push_back(beatData);
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d errors %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [127:0] got, exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [2:0] idx, input logic [31:0] d);
      @(negedge mclk);
      regWrite = 1'b1;
      regIndex = idx;
      regWrData = d;
      @(negedge mclk);
      regWrite = 1'b0;
   endtask
   task automatic rdc(input logic [2:0] idx, input logic [31:0] exp);
      @(negedge mclk);
      regRead = 1'b1;
      regIndex = idx;
      @(negedge mclk);
      regRead = 1'b0;
      chk("read valid", regRdValid, 1'b1);
      chk("read data", regRdData, exp);
   endtask
   task automatic wait_done();
      for (n = 0; n < 2000 && completePulse !== 1'b1; n++) @(negedge mclk);
      chk("complete", completePulse, 1'b1);
      for (n = 0; n < 60 && beatValid !== 1'b0; n++) @(negedge mclk);
   endtask
   task automatic setup(input logic [31:0] a, md, input int lc, w, z,
                        input logic [15:0] s);
      wr(VDS_IDX_MEMORY_ADDRESS_DEF, a);
      wr(VDS_IDX_LINE_SIZE_COUNTS, {lc[15:0], w[15:0]});
      wr(VDS_IDX_LINE_STRIDE_ZOOM, {6'h0, z[9:0], s});
      wr(VDS_IDX_TRANSFER_MODE, md);
   endtask
   // Reference walk of the descriptor: lines, zoom passes, bytes
   task automatic model(input logic [31:0] a, t, md, input int lc, w, z,
                        input logic [15:0] s);
      vds_beat_t b;
      logic [31:0] adr;
      adr = a;
      for (int l = 0; l < lc; l++) begin
         for (int k = 0; k < z; k++) begin
            for (int i = 0; i < w; i++) begin
               b.memAddr = translateEn ? {1'b0, adr[30:0]} : adr;
               b.busAddr = (t & ~protectMask) | (addressSubstitute & protectMask);
               b.fillData = t;
               b.memWrite = (md[1:0] == 2'h2);
               b.fillNoBus = b.memWrite & md[3];
               b.snoop = md[5];
               b.longBurst = md[6];
               expQ.push_back(b);
               adr = md[4] ? adr + 32'h1 : adr - 32'h1;
            end
            if (k < z - 1)
               adr = md[4] ? adr - w : adr + w;
         end
         adr = adr + {{16{s[15]}}, s};
      end
      finalAddr = adr;
   endtask
   task automatic cmp_beats();
      vds_beat_t g, e;
      chk("beat count", gotQ.size(), expQ.size());
      while (expQ.size() > 0 && gotQ.size() > 0) begin
         e = expQ.pop_front();
         g = gotQ.pop_front();
         chk("beat", g, e);
      end
      expQ.delete();
      gotQ.delete();
   endtask
   task automatic launch(input logic [31:0] a, t, md, input int lc, w, z,
                         input logic [15:0] s, input bit syn);
      model(a, t, md, lc, w, z, s);
      wr(VDS_IDX_DEVICE_TARGET_GO, t);
      if (syn) begin
         repeat (20) @(negedge mclk);
         chk("sync hold", gotQ.size(), 0);
         externalSyncIn = 1'b1;
      end
      wait_done();
      externalSyncIn = 1'b0;
      chk("supported", typeUnsupported, 1'b0);
      cmp_beats();
      rdc(VDS_IDX_MEMORY_ADDRESS, finalAddr);
      rdc(VDS_IDX_LINE_SIZE_COUNTS, {16'h0, w[15:0]});
      rdc(VDS_IDX_LINE_PROGRESS, {6'h0, z[9:0], w[15:0]});
      rdc(VDS_IDX_DEVICE_TARGET, t);
   endtask

   initial begin
      {rst_b, regWrite, regRead, regIndex, regWrData, faultIn} = '0;
      {haltReq, externalSyncIn, stallEn, protectMask} = '0;
      addressSubstitute = 32'h0;
      translateEn = 1'b1;
      void'($urandom(2087));
      repeat (6) @(negedge mclk);
      rst_b = 1'b1;
      for (int i = 0; i < 8; i++) rdc(3'(i), 32'h0);
      wr(VDS_IDX_MEMORY_ADDRESS_DEF, 32'h8000_1000);
      rdc(VDS_IDX_MEMORY_ADDRESS, 32'h8000_1000);
      rdc(VDS_IDX_LINE_SIZE_COUNTS, 32'h0001_000C);
      rdc(VDS_IDX_LINE_STRIDE_ZOOM, 32'h0001_0000);
      rdc(VDS_IDX_LINE_PROGRESS, 32'h0001_000C);
      rdc(VDS_IDX_TRANSFER_MODE, 32'h28);
      stallEn = 1'b1;
      launch(32'h8000_1000, 32'h1F00_0040, 32'h28, 1, 12, 1, 16'h0, 0);
      setup(32'h200, 32'h14, 2, 3, 2, 16'h4);
      launch(32'h200, 32'h300, 32'h14, 2, 3, 2, 16'h4, 1);
      for (int k = 1; k < 4; k += 2) begin
         wr(VDS_IDX_MEMORY_ADDRESS_DEF, 32'h100);
         wr(VDS_IDX_TRANSFER_MODE, 32'(k));
         wr(VDS_IDX_DEVICE_TARGET_GO, 32'h0);
         wait_done();
         chk("unsupported", typeUnsupported, 1'b1);
         chk("no beats", gotQ.size(), 0);
      end
      for (int i = 0; i < 12; i++) begin
         m = $urandom & 32'h78;
         m[1] = $urandom;
         translateEn = $urandom;
         protectMask = $urandom;
         addressSubstitute = $urandom;
         stallEn = $urandom;
         st = 16'($urandom % 17) - 16'h8;
         setup(i * 32'h1000 + 32'h8000_0800, m, 1 + i % 3, 1 + i % 5,
               1 + i % 3, st);
         launch(i * 32'h1000 + 32'h8000_0800, $urandom, m, 1 + i % 3,
                1 + i % 5, 1 + i % 3, st, 0);
      end
      model(32'h400, 32'h5, 32'h10, 3, 20, 1, 16'h0);
      setup(32'h400, 32'h10, 3, 20, 1, 16'h0);
      wr(VDS_IDX_DEVICE_TARGET_GO, 32'h5);
      repeat (8) @(negedge mclk);
      faultIn = 1'b1;
      @(negedge mclk);
      faultIn = 1'b0;
      seen = 1'b0;
      for (n = 0; n < 4; n++) begin
         if (faultPulse === 1'b1)
            seen = 1'b1;
         @(negedge mclk);
      end
      chk("fault pulse", seen, 1'b1);
      repeat (10) @(negedge mclk);
      chk("stopped", busy, 1'b0);
      wr(VDS_IDX_DEVICE_TARGET_GO, 32'h5);
      repeat (6) @(negedge mclk);
      haltReq = 1'b1;
      repeat (6) @(negedge mclk);
      chk("halted", busy, 1'b0);
      haltReq = 1'b0;
      wr(VDS_IDX_DEVICE_TARGET_GO, 32'h5);
      wait_done();
      cmp_beats();
      rdc(VDS_IDX_MEMORY_ADDRESS, finalAddr);
      finish_test();
   end
endmodule
